// [verilog/tpos_scheduler.sv]
// Time-proportional output scheduler for four pulse outputs.
// Assumes settings and control inputs come from logic on clock_i, so no
// synchroniser is needed; outputs drive relay or solid-state drivers.
`timescale 1ns/1ns
// Functional notes
// - Output ON for value fraction of period
// - Period setting 0 to 99 s, default 2
// - Zero period setting means half a second
// - Period, width, scaling change only while stopped
// - Minimum width forces full OFF or full ON
// - Durations in 2 ms steps, at least one
// - Scheduling caps ON fraction: 100, 50, 25 %
// - Method codes 0,1,2; quarter invalid two-channel
// - While scheduling, limit is lesser of scheduling and value limit
// - Delay 0 to 1000 ms, odd rounds down
// - Method and delay load at reset only
// - Scheduling needs all channels in standard mode
// - Limit applies to every value source
// - Scheduled outputs use first_output period
// - Self tuning inhibited when method not none
// - Delay offsets slots and lengthens the cycle
// - Scaling maps upper to 100, lower to 0
// - Scaling limits -1999 to 9999, defaults 100/0
// - Decimal point code places limit fraction digits
// - Scaling only for PID heat or cool outputs
// - Time slicing only on PID assigned pulse outputs
module tpos_scheduler import tpos_pkg::*; #(
	parameter int TICK_CYCLES = TICK_CYCLES_DFLT
) (
	// Clock, reset, enable
	input logic clock_i,
	input logic rst_i,
	input logic ce_i,
	// Unit status
	input logic run_i,
	input logic soft_reset_i,
	input logic two_ch_variant_i,
	input logic linear_variant_i,
	// Unit scheduling settings
	input logic [1:0] sched_method_i,
	input logic [9:0] sched_delay_ms_i,
	// Per-output settings and control
	input tpos_cfg_t [NCH-1:0] ch_cfg_i,
	input tpos_ctl_t [NCH-1:0] ch_ctl_i,
	// Pulse outputs and status
	output logic [NCH-1:0] pulse_o,
	output logic self_tuning_inhibit_o,
	output logic sched_active_o,
	output logic [1:0] eff_method_o,
	output logic [9:0] eff_delay_ms_o
);

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	logic [TICK_W-1:0] tick_cnt_q;      // Prescaler to the 2 ms tick
	logic tick;                         // One-cycle tick strobe
	logic load_pend_q;                  // Unit settings wait for loading
	tpos_sched_t method_q;              // Method in force
	logic [9:0] delay_q;                // Delay in force, even ms
	tpos_cfg_t [NCH-1:0] cfg_q;         // Settings in force
	logic sched_on;                     // Scheduling in force
	logic all_std;                      // Every channel standard mode
	logic [PER_W-1:0] delay_t;          // Delay in ticks
	logic [PER_W-1:0] base_per;         // First output period in ticks
	logic [PER_W-1:0] cyc_len;          // Scheduled cycle in ticks
	logic [PER_W-1:0] sh_cnt_q;         // Shared scheduled position
	logic [PER_W-1:0] own_cnt_q [NCH];  // Own-period positions
	logic [PER_W-1:0] per_own [NCH];    // Own period in ticks
	logic [PER_W-1:0] per_use [NCH];    // Period in use
	logic [PER_W-1:0] start [NCH];      // Slot start in the cycle
	logic [PER_W-1:0] pos [NCH];        // Position from slot start
	logic [PER_W-1:0] on_calc [NCH];    // ON ticks from current value
	logic [PER_W-1:0] on_lat_q [NCH];   // ON ticks for this period
	logic [9:0] pct_s [NCH];            // Scaled percentages
	logic [9:0] pct_f [NCH];            // After width and limit
	logic [9:0] limit [NCH];            // Upper ON limit
	logic [NCH-1:0] appl;               // Time slicing applies
	logic [9:0] sched_lim;              // Limit from the method

	// ------------------------------------------------------------------
	// Output tick
	// ------------------------------------------------------------------
	assign tick = (tick_cnt_q == TICK_W'(TICK_CYCLES - 1));

	// Prescaler giving the 2 ms output resolution
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			tick_cnt_q <= '0;
		end else if (ce_i) begin
			if (tick) begin
				tick_cnt_q <= '0;
			end else begin
				tick_cnt_q <= tick_cnt_q + TICK_W'(1);
			end
		end
	end

	// ------------------------------------------------------------------
	// Unit settings, loaded only at reset
	// ------------------------------------------------------------------
	// Power-on takes the defaults, then loads ports right after release
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			load_pend_q <= 1'b1;
			method_q <= SCHED_NONE;
			delay_q <= DELAY_DFLT_MS;
		end else if (ce_i) begin
			if (load_pend_q || soft_reset_i) begin
				load_pend_q <= 1'b0;
				// Unknown code and quarter on two channels fall to none
				if (sched_method_i == 2'(SCHED_HALF)) begin
					method_q <= SCHED_HALF;
				end else if (sched_method_i == 2'(SCHED_QUARTER) &&
					!two_ch_variant_i) begin
					method_q <= SCHED_QUARTER;
				end else begin
					method_q <= SCHED_NONE;
				end
				// Clip to range, drop odd millisecond
				if (sched_delay_ms_i > DELAY_MAX_MS) begin
					delay_q <= DELAY_MAX_MS;
				end else begin
					delay_q <= {sched_delay_ms_i[9:1], 1'b0};
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Per-output settings, accepted only while stopped
	// ------------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			for (int k = 0; k < NCH; k++) begin
				cfg_q[k].period_s <= PERIOD_DFLT_S;
				cfg_q[k].min_width <= MINW_DFLT;
				cfg_q[k].scale_up <= SCALE_UP_DFLT;
				cfg_q[k].scale_lo <= SCALE_LO_DFLT;
				cfg_q[k].scaling_point_position <= DP_DFLT;
			end
		end else if (ce_i && !run_i) begin
			for (int k = 0; k < NCH; k++) begin
				// Out-of-range settings clip to the nearest legal value
				if (ch_cfg_i[k].period_s > PERIOD_MAX_S) begin
					cfg_q[k].period_s <= PERIOD_MAX_S;
				end else begin
					cfg_q[k].period_s <= ch_cfg_i[k].period_s;
				end
				if (ch_cfg_i[k].min_width > MINW_MAX) begin
					cfg_q[k].min_width <= MINW_MAX;
				end else begin
					cfg_q[k].min_width <= ch_cfg_i[k].min_width;
				end
				cfg_q[k].scale_up <= clip_scale(ch_cfg_i[k].scale_up);
				cfg_q[k].scale_lo <= clip_scale(ch_cfg_i[k].scale_lo);
				cfg_q[k].scaling_point_position <=
					ch_cfg_i[k].scaling_point_position;
			end
		end
	end

	// ------------------------------------------------------------------
	// Scaling of each assigned value
	// ------------------------------------------------------------------
	for (genvar g = 0; g < NCH; g++) begin : g_scale
		tpos_scaler u_scaler (
			.clock_i(clock_i),
			.rst_i(rst_i),
			.ce_i(ce_i),
			.en_i(ch_ctl_i[g].pid && ch_ctl_i[g].heat_cool),
			.value_i(ch_ctl_i[g].manipulated_value),
			.up_i(cfg_q[g].scale_up),
			.lo_i(cfg_q[g].scale_lo),
			.dp_i(cfg_q[g].scaling_point_position),
			.pct_o(pct_s[g])
		);
	end

	// ------------------------------------------------------------------
	// Scheduling state and slot layout
	// ------------------------------------------------------------------
	always_comb begin
		all_std = 1'b1;
		for (int k = 0; k < NCH; k++) begin
			all_std = all_std & ch_ctl_i[k].standard_mode;
		end
		sched_on = (method_q != SCHED_NONE) && all_std;
		case (method_q)
			SCHED_HALF: sched_lim = LIM_HALF;
			SCHED_QUARTER: sched_lim = LIM_QUARTER;
			default: sched_lim = PCT_FULL;
		endcase
		delay_t = PER_W'(delay_q[9:1]);
		base_per = period_ticks(cfg_q[0].period_s);
		cyc_len = base_per + PER_W'(32'(delay_t) * NCH);
		for (int k = 0; k < NCH; k++) begin
			per_own[k] = period_ticks(cfg_q[k].period_s);
			per_use[k] = sched_on ? base_per : per_own[k];
			// Slot start: method share plus one delay per output
			case (method_q)
				SCHED_HALF: start[k] =
					PER_W'(32'(k % 2) * 32'(base_per) / 2);
				SCHED_QUARTER: start[k] =
					PER_W'(32'(k) * 32'(base_per) / 4);
				default: start[k] = '0;
			endcase
			start[k] = start[k] + PER_W'(32'(k) * 32'(delay_t));
			if (!sched_on) begin
				pos[k] = own_cnt_q[k];
			end else if (sh_cnt_q >= start[k]) begin
				pos[k] = sh_cnt_q - start[k];
			end else begin
				pos[k] = PER_W'(17'(sh_cnt_q) + 17'(cyc_len) - 17'(start[k]));
			end
		end
	end

	// Shared scheduled cycle position
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			sh_cnt_q <= '0;
		end else if (ce_i) begin
			if (!sched_on) begin
				sh_cnt_q <= '0;
			end else if (tick) begin
				if (sh_cnt_q >= cyc_len - PER_W'(1)) begin
					sh_cnt_q <= '0;
				end else begin
					sh_cnt_q <= sh_cnt_q + PER_W'(1);
				end
			end
		end
	end

	// Own-period positions, free running
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			for (int k = 0; k < NCH; k++) begin
				own_cnt_q[k] <= '0;
			end
		end else if (ce_i && tick) begin
			for (int k = 0; k < NCH; k++) begin
				if (own_cnt_q[k] >= per_own[k] - PER_W'(1)) begin
					own_cnt_q[k] <= '0;
				end else begin
					own_cnt_q[k] <= own_cnt_q[k] + PER_W'(1);
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// ON duration per output
	// ------------------------------------------------------------------
	always_comb begin
		for (int k = 0; k < NCH; k++) begin
			appl[k] = ch_ctl_i[k].pid && ch_ctl_i[k].heat_cool &&
				!(linear_variant_i && k < 2);
			limit[k] = PCT_FULL;
			if (sched_on) begin
				// Lesser of method cap and value cap, for any source
				limit[k] = (ch_ctl_i[k].mv_limit < sched_lim) ?
					ch_ctl_i[k].mv_limit : sched_lim;
			end
			// Minimum width snaps near the ends
			pct_f[k] = pct_s[k];
			if (pct_s[k] < cfg_q[k].min_width) begin
				pct_f[k] = 10'h000;
			end else if (pct_s[k] >= PCT_FULL - cfg_q[k].min_width) begin
				pct_f[k] = PCT_FULL;
			end
			if (pct_f[k] > limit[k]) begin
				pct_f[k] = limit[k];
			end
			on_calc[k] = PER_W'(32'(pct_f[k]) * 32'(per_use[k]) /
				32'(PCT_FULL));
			if (pct_f[k] != 10'h000 && on_calc[k] == '0) begin
				on_calc[k] = PER_W'(1);
			end
		end
	end

	// ON duration is held for the whole period, taken at slot start
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			for (int k = 0; k < NCH; k++) begin
				on_lat_q[k] <= '0;
			end
		end else if (ce_i) begin
			for (int k = 0; k < NCH; k++) begin
				if (pos[k] == '0) begin
					on_lat_q[k] <= on_calc[k];
				end
			end
		end
	end

	// Pulse outputs: ON from slot start, OFF for the rest
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			pulse_o <= '0;
		end else if (ce_i) begin
			for (int k = 0; k < NCH; k++) begin
				if (!appl[k]) begin
					// Plain level, never on linear outputs
					pulse_o[k] <= ch_ctl_i[k].direct_on &&
						!(linear_variant_i && k < 2);
				end else if (pos[k] == '0) begin
					pulse_o[k] <= (on_calc[k] != '0);
				end else begin
					pulse_o[k] <= (pos[k] < on_lat_q[k]);
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Status outputs
	// ------------------------------------------------------------------
	assign self_tuning_inhibit_o = (method_q != SCHED_NONE);
	assign sched_active_o = sched_on;
	assign eff_method_o = method_q;
	assign eff_delay_ms_o = delay_q;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	a_width_off: assert property (@(posedge clock_i) disable iff (rst_i)
		pct_s[0] < cfg_q[0].min_width |-> on_calc[0] == '0)
		else $error("value below minimum width not forced off");
	a_width_full: assert property (@(posedge clock_i) disable iff (rst_i)
		!sched_on && pct_s[0] >= PCT_FULL - cfg_q[0].min_width
		|-> on_calc[0] == per_use[0])
		else $error("value near full not forced on");
	a_min_step: assert property (@(posedge clock_i) disable iff (rst_i)
		pct_f[1] != 10'h000 |-> on_calc[1] != '0)
		else $error("nonzero value gave zero on time");
	a_cfg_frozen: assert property (@(posedge clock_i) disable iff (rst_i)
		run_i |=> $stable(cfg_q))
		else $error("settings changed while running");
	a_method_held: assert property (@(posedge clock_i) disable iff (rst_i)
		!soft_reset_i && !load_pend_q |=> $stable(method_q) && $stable(delay_q))
		else $error("method or delay changed without reset");
	a_quarter_cap: assert property (@(posedge clock_i) disable iff (rst_i)
		sched_on && method_q == SCHED_QUARTER |-> on_calc[2] <= base_per / 4)
		else $error("quarter method exceeded its share");
	a_zero_period: assert property (@(posedge clock_i) disable iff (rst_i)
		cfg_q[3].period_s == 7'h00 |-> per_own[3] == HALF_PERIOD_TICKS)
		else $error("zero period not half a second");
	a_two_ch_quarter: assert property (@(posedge clock_i) disable iff (rst_i)
		ce_i && soft_reset_i && two_ch_variant_i |=> method_q != SCHED_QUARTER)
		else $error("quarter method on two-channel unit");
	a_delay_even: assert property (@(posedge clock_i) disable iff (rst_i)
		ce_i && soft_reset_i |=> !delay_q[0] && delay_q <= DELAY_MAX_MS)
		else $error("delay odd or out of range");
	a_shared_period: assert property (@(posedge clock_i) disable iff (rst_i)
		sched_on |-> per_use[3] == per_own[0] && per_use[1] == per_own[0])
		else $error("scheduled output not on first period");
	a_slot_start: assert property (@(posedge clock_i) disable iff (rst_i)
		ce_i && appl[0] && pos[0] == '0 && on_calc[0] != '0 |=> pulse_o[0])
		else $error("output not on at slot start");
	a_st_inhibit: assert property (@(posedge clock_i) disable iff (rst_i)
		sched_on |-> self_tuning_inhibit_o)
		else $error("self tuning not inhibited while scheduling");

endmodule : tpos_scheduler

// [verilog/tpos_pkg.sv]
// Constants, types and helpers of the time-proportional output scheduler.
// Assumes a single 250 MHz clock and percent values in tenths of a percent.
package tpos_pkg;

	// ------------------------------------------------------------------
	// Sizes and timing
	// ------------------------------------------------------------------
	localparam int NCH = 4;                 // Pulse outputs of the unit
	localparam int CLK_PERIOD_NS = 4;       // Clock period in ns
	localparam int TICK_MS = 2;             // Output resolution in ms
	localparam int NS_PER_MS = 1_000_000;   // Unit conversion
	localparam int TICK_CYCLES_DFLT = TICK_MS * NS_PER_MS / CLK_PERIOD_NS;
	localparam int TICK_W = 20;             // Width of the tick prescaler
	localparam int PER_W = 16;              // Width of period counts in ticks
	localparam int MS_PER_S = 1000;         // Unit conversion
	localparam int HALF_PERIOD_MS = 500;    // Period used for a zero setting
	localparam logic [PER_W-1:0] HALF_PERIOD_TICKS =
		PER_W'(HALF_PERIOD_MS / TICK_MS);

	// ------------------------------------------------------------------
	// Settings: ranges and reset values
	// ------------------------------------------------------------------
	localparam logic [6:0] PERIOD_MAX_S = 7'h63;    // 99 s
	localparam logic [6:0] PERIOD_DFLT_S = 7'h02;   // 2 s
	localparam logic [9:0] PCT_FULL = 10'h3E8;      // 100.0 %
	localparam logic [9:0] LIM_HALF = 10'h1F4;      // 50.0 %
	localparam logic [9:0] LIM_QUARTER = 10'h0FA;   // 25.0 %
	localparam logic [9:0] MINW_MAX = 10'h1F4;      // 50.0 %
	localparam logic [9:0] MINW_DFLT = 10'h000;     // Width off
	localparam logic [9:0] DELAY_MAX_MS = 10'h3E8;  // 1000 ms
	localparam logic [9:0] DELAY_DFLT_MS = 10'h00A; // 10 ms
	localparam logic signed [15:0] SCALE_MAX = 16'sh270F;  // 9999
	localparam logic signed [15:0] SCALE_MIN = 16'shF831;  // -1999
	localparam logic signed [15:0] SCALE_UP_DFLT = 16'sh0064;
	localparam logic signed [15:0] SCALE_LO_DFLT = 16'sh0000;
	localparam logic [1:0] DP_DFLT = 2'h0;
	localparam int SCALE_GAIN = 100;        // Tenths of percent over ratio

	// Scheduling method, encoded 0, 1, 2 as set by software
	typedef enum logic [1:0] {
		SCHED_NONE,
		SCHED_HALF,
		SCHED_QUARTER
	} tpos_sched_t;

	// Per-output settings that may only change while stopped
	typedef struct packed {
		logic [6:0] period_s;           // Control period in seconds
		logic [9:0] min_width;          // Minimum ON/OFF width, 0.1 %
		logic signed [15:0] scale_up;   // Upper scaling limit
		logic signed [15:0] scale_lo;   // Lower scaling limit
		logic [1:0] scaling_point_position; // Fraction digits of limits
	} tpos_cfg_t;

	// Per-output live control inputs
	typedef struct packed {
		logic signed [15:0] manipulated_value; // Assigned value, 0.1 %
		logic [9:0] mv_limit;       // Upper manipulated value limit
		logic pid;                  // Channel runs two-degree PID
		logic heat_cool;            // Assigned to a heat or cool output
		logic standard_mode;        // Channel output mode is standard
		logic direct_on;            // Level used when not time-sliced
	} tpos_ctl_t;

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	// Period setting in seconds to a count of output ticks
	function automatic logic [PER_W-1:0] period_ticks(input logic [6:0] s);
		logic [PER_W-1:0] t;
		t = PER_W'(32'(s) * (MS_PER_S / TICK_MS));
		if (s == 7'h00) begin
			t = HALF_PERIOD_TICKS;
		end
		return t;
	endfunction : period_ticks

	// Scaling limit clipped to its legal range
	function automatic logic signed [15:0] clip_scale(
		input logic signed [15:0] v);
		logic signed [15:0] r;
		r = v;
		if (v > SCALE_MAX) begin
			r = SCALE_MAX;
		end else if (v < SCALE_MIN) begin
			r = SCALE_MIN;
		end
		return r;
	endfunction : clip_scale

	// Power of ten for a decimal point code
	function automatic logic signed [39:0] pow10(input logic [1:0] dp);
		logic signed [39:0] r;
		case (dp)
			2'h0: r = 40'sh00_0000_0001;
			2'h1: r = 40'sh00_0000_000A;
			2'h2: r = 40'sh00_0000_0064;
			default: r = 40'sh00_0000_03E8;
		endcase
		return r;
	endfunction : pow10

endpackage : tpos_pkg

// [verilog/tpos_scaler.sv]
// Linear output scaling of one assigned value to a percentage.
// Assumes limits already clipped; result is registered, one cycle late.
`timescale 1ns/1ns
module tpos_scaler import tpos_pkg::*; (
	// Clock, reset, enable
	input logic clock_i,
	input logic rst_i,
	input logic ce_i,
	// Scaling request
	input logic en_i,
	input logic signed [15:0] value_i,
	input logic signed [15:0] up_i,
	input logic signed [15:0] lo_i,
	input logic [1:0] dp_i,
	// Result in tenths of a percent
	output logic [9:0] pct_o
);

	logic signed [39:0] num;   // Value minus lower limit, common units
	logic signed [39:0] den;   // Span of the limits
	logic signed [39:0] quo;   // Raw scaled percentage
	logic [9:0] pct_d;

	// ------------------------------------------------------------------
	// Scaling arithmetic
	// ------------------------------------------------------------------
	// Value is in 0.1 %, limits carry dp fraction digits
	always_comb begin
		num = 40'(value_i) * pow10(dp_i) - 40'(lo_i) * 40'sd10;
		den = 40'(up_i) - 40'(lo_i);
		quo = 40'sd0;
		if (den != 40'sd0) begin
			quo = (num * 40'(SCALE_GAIN)) / den;
		end
		if (!en_i) begin
			// Unscaled: value passes as a percentage
			quo = 40'(value_i);
		end
		// Clamp into 0 .. 100 %
		if (quo < 40'sd0) begin
			pct_d = 10'h000;
		end else if (quo > 40'(PCT_FULL)) begin
			pct_d = PCT_FULL;
		end else begin
			pct_d = quo[9:0];
		end
	end

	// Result register
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			pct_o <= 10'h000;
		end else if (ce_i) begin
			pct_o <= pct_d;
		end
	end

endmodule : tpos_scaler

// [sim/tpos_relay_model.sv]
// Load model: counts clock cycles that each pulse output energises.
// Assumes pulse outputs are registered on the same clock.
`timescale 1ns/1ns
module tpos_relay_model import tpos_pkg::*; (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// Pulse outputs seen by the load
	input wire logic [NCH-1:0] pulse_i,
	// Energised cycles per output
	output logic [NCH-1:0][31:0] on_cnt_o
);
	// Accumulate ON time; period choice is left to software
	always_ff @(posedge clock_i) begin
		for (int k = 0; k < NCH; k++) begin
			if (rst_i) begin
				on_cnt_o[k] <= 32'h0000_0000;
			end else if (pulse_i[k]) begin
				on_cnt_o[k] <= on_cnt_o[k] + 32'h0000_0001;
			end
		end
	end
endmodule : tpos_relay_model

// [sim/tpos_scheduler_test.sv]
// Self-checking bench of the pulse scheduler with a 2-cycle tick.
// Assumes the load model counts ON cycles of each output.
`timescale 1ns/1ns
module tpos_scheduler_test import tpos_pkg::*;;
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	logic run_i = 1'b0;
	logic soft_reset_i = 1'b0;
	logic [1:0] sched_method_i = 2'h0;
	logic [9:0] sched_delay_ms_i = 10'h00B; // Odd on purpose
	logic two_ch_variant_i = 1'b0;          // Two-channel unit strap
	logic linear_variant_i = 1'b0;          // Linear outputs 0 and 1 strap
	tpos_cfg_t [NCH-1:0] cfg;
	tpos_ctl_t [NCH-1:0] ctl;
	logic [NCH-1:0] pulse_o;
	logic self_tuning_inhibit_o;
	logic sched_active_o;
	logic [1:0] eff_method_o;
	logic [9:0] eff_delay_ms_o;
	logic [NCH-1:0][31:0] on_cnt;
	int miscompares = 0;
	int n_compared = 0;

	// 250 MHz clock
	always #2 clock_i = ~clock_i;

	tpos_scheduler #(.TICK_CYCLES(2)) DUT (.clock_i(clock_i),
		.rst_i(rst_i), .ce_i(1'b1), .run_i(run_i),
		.soft_reset_i(soft_reset_i),
		.two_ch_variant_i(two_ch_variant_i),
		.linear_variant_i(linear_variant_i),
		.sched_method_i(sched_method_i),
		.sched_delay_ms_i(sched_delay_ms_i), .ch_cfg_i(cfg),
		.ch_ctl_i(ctl), .pulse_o(pulse_o),
		.self_tuning_inhibit_o(self_tuning_inhibit_o),
		.sched_active_o(sched_active_o), .eff_method_o(eff_method_o),
		.eff_delay_ms_o(eff_delay_ms_o));

	tpos_relay_model load (.clock_i(clock_i), .rst_i(rst_i),
		.pulse_i(pulse_o), .on_cnt_o(on_cnt));

	// Inputs change 1 ns after the rising edge
	task step(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask : step

	task check(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %0d seen %0d", nm, exp, seen);
		end
	endtask : check

	// Settle two 0.5 s periods (500 cycles each), count ON over two more
	task meas(input logic [15:0] mv, input logic [31:0] exp);
		logic [31:0] c0;
		ctl[0].manipulated_value = mv;
		step(1000);
		c0 = on_cnt[0];
		step(1000);
		check("on_cycles", on_cnt[0] - c0, exp);
	endtask : meas

	// Software reset loads method and delay
	task reload(input logic [1:0] m, input logic [9:0] d);
		sched_method_i = m;
		sched_delay_ms_i = d;
		soft_reset_i = 1'b1;
		step(1);
		soft_reset_i = 1'b0;
		step(1);
	endtask : reload

	task t_load;
		check("eff_delay", 32'(eff_delay_ms_o), 32'h0000_000A);
		sched_method_i = 2'h1;
		step(3);
		check("eff_method", 32'(eff_method_o), 32'h0000_0000);
		for (int m = 2; m >= 0; m--) begin
			reload(2'(m), 10'h000);
			check("eff_method", 32'(eff_method_o), 32'(m));
			check("inhibit", 32'(self_tuning_inhibit_o),
				32'(m != 0));
		end
		$display("t_load done");
	endtask : t_load

	// Zero period gives 250 ticks of 2 cycles
	task t_duty;
		meas(16'sh01F4, 32'h0000_01F4);
		meas(16'sh0001, 32'h0000_0004);
		$display("t_duty done");
	endtask : t_duty

	// Width 10.0 %: small values off, large values fully on
	task t_minw;
		cfg[0].min_width = 10'h064;
		meas(16'sh0032, 32'h0000_0000);
		meas(16'sh03B6, 32'h0000_03E8);
		run_i = 1'b1;
		cfg[0].min_width = 10'h000;
		meas(16'sh0032, 32'h0000_0000);
		run_i = 1'b0;
		$display("t_minw done");
	endtask : t_minw

	// Quarter method caps at 25 %, then the lower value limit wins
	task t_sched;
		step(2);
		reload(2'h2, 10'h000);
		check("active", 32'(sched_active_o), 32'h0000_0001);
		meas(16'sh01F4, 32'h0000_00F8);
		ctl[0].mv_limit = 10'h064;
		meas(16'sh01F4, 32'h0000_0064);
		$display("t_sched done");
	endtask : t_sched

	// Half method, 10 ms delay: 270-tick cycle (540 clocks), 125 ticks ON
	// on outputs 0 and 1; output 1 keeps its own 1 s setting but must follow
	// the first output's period while scheduling
	task t_delay;
		logic [31:0] c0;
		logic [31:0] c1;
		ctl[0].mv_limit = 10'h3E8;
		ctl[1].manipulated_value = 16'sh01F4;
		cfg[1].period_s = 7'h01;
		reload(2'h1, 10'h00A);
		step(1080);
		c0 = on_cnt[0];
		c1 = on_cnt[1];
		step(1080);
		check("on_cycles_0", on_cnt[0] - c0, 32'h0000_01F4);
		check("on_cycles_1", on_cnt[1] - c1, 32'h0000_01F4);
		$display("t_delay done");
	endtask : t_delay

	// Variant straps: quarter refused on two channels, linear outputs off
	task t_variant;
		logic [31:0] c1;
		two_ch_variant_i = 1'b1;
		reload(2'h2, 10'h000);
		check("eff_method", 32'(eff_method_o), 32'h0000_0000);
		two_ch_variant_i = 1'b0;
		ctl[1].pid = 1'b0;
		ctl[1].direct_on = 1'b1;
		linear_variant_i = 1'b1;
		step(2);
		c1 = on_cnt[1];
		step(100);
		check("linear_off", on_cnt[1] - c1, 32'h0000_0000);
		linear_variant_i = 1'b0;
		step(2);
		c1 = on_cnt[1];
		step(100);
		check("direct_on", on_cnt[1] - c1, 32'h0000_0064);
		$display("t_variant done");
	endtask : t_variant

	task results;
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : results

	// Main sequence: limits 1000/0 with one fraction digit
	initial begin
		cfg = '0;
		ctl = '0;
		for (int k = 0; k < NCH; k++) begin
			cfg[k].scale_up = 16'sh03E8;
			cfg[k].scaling_point_position = 2'h1;
			ctl[k].mv_limit = 10'h3E8;
			ctl[k].pid = 1'b1;
			ctl[k].heat_cool = 1'b1;
			ctl[k].standard_mode = 1'b1;
		end
		step(4);
		rst_i = 1'b0;
		step(2);
		t_load;
		t_duty;
		t_minw;
		t_sched;
		t_delay;
		t_variant;
		results;
	end
endmodule : tpos_scheduler_test
